// file: rtl/dmx_map.vh
// register offsets, config field positions and reset values for the slice datapath
`ifndef DMX_MAP_VH
`define DMX_MAP_VH

`define DMX_OFS_CFG      5'h00
`define DMX_OFS_STATUS   5'h04
`define DMX_OFS_IRQ_MASK 5'h08
`define DMX_OFS_PATTERN  5'h0C
`define DMX_OFS_PAT_MASK 5'h10
`define DMX_OFS_ACC_LO   5'h14
`define DMX_OFS_ACC_HI   5'h18

`define DMX_F_MULT_A     0
`define DMX_F_MULT_B     2
`define DMX_F_ADD_A      4
`define DMX_F_ADD_B      6
`define DMX_F_CIN        7
`define DMX_F_BYPASS     8
`define DMX_F_ROUT       9
`define DMX_F_WIDE48     11
`define DMX_F_FWD_RES    12
`define DMX_F_FWD_CARRY  14
`define DMX_F_PREADD     15
`define DMX_CFG_BITS     17

`define DMX_ST_POS_OVF   0
`define DMX_ST_NEG_OVF   1
`define DMX_ST_MATCH     2
`define DMX_ST_BITS      3

`define DMX_CFG_RESET    17'h00000
`define DMX_MASK_RESET   3'h0
`define DMX_PAT_RESET    32'h00000000
`define DMX_PMASK_RESET  32'h00000000

`define DMX_SHIFT_A      18
`define DMX_SHIFT_B      17

`define DMX_RESP_OKAY    2'h0
`define DMX_RESP_SLVERR  2'h2

`endif

// file: rtl/dmx_preadd.v
// 27-bit pre-adder with add, subtract and reverse subtract
`timescale 1ns/100ps
module dmx_preadd (
  input  wire [1:0]  op_i,
  input  wire [26:0] a_i,
  input  wire [26:0] b_i,
  output reg  [26:0] sum_o
);
  always @* begin
    case (op_i)
      2'h0:    sum_o = a_i + b_i;
      2'h1:    sum_o = a_i - b_i;
      2'h2:    sum_o = b_i - a_i;
      // undefined operation yields zero rather than a guess
      default: sum_o = 27'h0000000;
    endcase
  end
endmodule // dmx_preadd

// file: rtl/dmx_slice.v
// multiply-accumulate slice operand and result routing with AXI4-Lite config
//
// Operation
// - mult A select: sign-extended a, pre-adder, register file, zero-extended a.
// - mult B select: b, forward operand cascade, pre-adder, register file.
// - bypass feeds adder A operand straight to the result register.
// - adder A: product sign-extended, product shifted left 18, forward result.
// - adder A code 10: sign-extended {index, a, b}.
// - adder B: own registered result or forward result cascade.
// - adder B source shifted right seventeen when shift control is high.
// - carry-in: local carry or cascade carry from slice below.
// - 45-bit result: sum low, sum upper 32, reverse cascade low 32.
// - wide mode puts result bits 47, 46, 45 on flag outputs.
// - normal mode flags show overflows and pattern match.
// - carry out from bit 48 in wide mode, else bit 64.
// - forward result out: unregistered sum, registered sum, or passthrough.
// - cascade carry out: own carry or passthrough input.
// - pre-adder computes a+b, a-b or b-a, 27 bits.
//
// Our own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/100ps
`include "dmx_map.vh"
module dmx_slice (
  input  wire        clk_i,
  input  wire        resetn_i,
  input  wire [4:0]  s_axi_awaddr_i,
  input  wire        s_axi_awvalid_i,
  output wire        s_axi_awready_o,
  input  wire [31:0] s_axi_wdata_i,
  input  wire [3:0]  s_axi_wstrb_i,
  input  wire        s_axi_wvalid_i,
  output wire        s_axi_wready_o,
  output reg  [1:0]  s_axi_bresp_o,
  output reg         s_axi_bvalid_o,
  input  wire        s_axi_bready_i,
  input  wire [4:0]  s_axi_araddr_i,
  input  wire        s_axi_arvalid_i,
  output wire        s_axi_arready_o,
  output reg  [31:0] s_axi_rdata_o,
  output reg  [1:0]  s_axi_rresp_o,
  output reg         s_axi_rvalid_o,
  input  wire        s_axi_rready_i,
  input  wire [17:0] a_i,
  input  wire [26:0] b_i,
  input  wire [26:0] regfile_data_i,
  input  wire [2:0]  regfile_index_i,
  input  wire [26:0] fwd_operand_casc_i,
  input  wire [63:0] fwd_result_casc_i,
  input  wire [31:0] rev_result_casc_i,
  input  wire        local_carry_i,
  input  wire        cascade_carry_i,
  input  wire        cascade_carry_pass_i,
  input  wire        right_shift17_i,
  output reg  [44:0] result_o,
  output reg         pos_ovf_o,
  output reg         neg_ovf_o,
  output reg         match_o,
  output reg         result_carry_o,
  output reg  [63:0] fwd_result_casc_o,
  output wire        cascade_carry_o,
  output wire        irq_o
);
  reg  [`DMX_CFG_BITS-1:0] cfg;
  reg  [`DMX_ST_BITS-1:0]  status;
  reg  [`DMX_ST_BITS-1:0]  irq_mask;
  reg  [31:0]              pattern;
  reg  [31:0]              pat_mask;
  reg  [63:0]              acc;
  reg  [4:0]               aw_addr;
  reg                      aw_held;
  reg  [31:0]              w_data;
  reg  [3:0]               w_strb;
  reg                      w_held;

  wire [1:0] sel_mult_a  = cfg[`DMX_F_MULT_A+1:`DMX_F_MULT_A];
  wire [1:0] sel_mult_b  = cfg[`DMX_F_MULT_B+1:`DMX_F_MULT_B];
  wire [1:0] sel_add_a   = cfg[`DMX_F_ADD_A+1:`DMX_F_ADD_A];
  wire       sel_add_b   = cfg[`DMX_F_ADD_B];
  wire       sel_cin     = cfg[`DMX_F_CIN];
  wire       bypass      = cfg[`DMX_F_BYPASS];
  wire [1:0] sel_rout    = cfg[`DMX_F_ROUT+1:`DMX_F_ROUT];
  wire       wide48      = cfg[`DMX_F_WIDE48];
  wire [1:0] sel_fwd_res = cfg[`DMX_F_FWD_RES+1:`DMX_F_FWD_RES];
  wire       sel_fwd_c   = cfg[`DMX_F_FWD_CARRY];
  wire [1:0] sel_preadd  = cfg[`DMX_F_PREADD+1:`DMX_F_PREADD];

  // shared by the write and read decoders
  function is_mapped;
    input [4:0] addr;
    begin
      is_mapped = (addr == `DMX_OFS_CFG) || (addr == `DMX_OFS_STATUS) ||
                  (addr == `DMX_OFS_IRQ_MASK) || (addr == `DMX_OFS_PATTERN) ||
                  (addr == `DMX_OFS_PAT_MASK) || (addr == `DMX_OFS_ACC_LO) ||
                  (addr == `DMX_OFS_ACC_HI);
    end
  endfunction

  function [31:0] apply_strb;
    input [31:0] old;
    input [31:0] data;
    input [3:0]  strb;
    integer k;
    begin
      apply_strb = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (strb[k]) begin
          apply_strb[k*8 +: 8] = data[k*8 +: 8];
        end
      end
    end
  endfunction

  // ---------------- datapath ----------------
  wire [26:0] preadd_sum;

  dmx_preadd u_preadd (
    .op_i  (sel_preadd),
    .a_i   ({{9{a_i[17]}}, a_i}),
    .b_i   (b_i),
    .sum_o (preadd_sum)
  );

  reg  [18:0] mult_a;
  reg  [26:0] mult_b;
  reg  [63:0] add_a;
  reg  [63:0] add_b_src;
  reg  [63:0] add_b_shr;
  reg  [63:0] add_b;
  reg         add_cin;
  reg  [63:0] sum_out;
  reg         carry64;
  reg         carry48;
  reg         ovf_pos;
  reg         ovf_neg;
  reg  [44:0] next_result;
  wire [45:0] product = $signed(mult_a) * $signed(mult_b);
  wire [47:0] packed_ab = {regfile_index_i, a_i, b_i};
  wire [64:0] sum_wide = {1'b0, add_a} + {1'b0, add_b} + {64'h0, add_cin};
  wire [48:0] sum_low = {1'b0, add_a[47:0]} + {1'b0, add_b[47:0]} + {48'h0, add_cin};
  wire        pat_hit = ((sum_out[31:0] ^ pattern) & pat_mask) == 32'h00000000;
  wire        own_carry = wide48 ? carry48 : carry64;

  always @* begin
    case (sel_mult_a)
      2'h0:    mult_a = {a_i[17], a_i};
      2'h1:    mult_a = preadd_sum[18:0];
      2'h2:    mult_a = regfile_data_i[18:0];
      default: mult_a = {1'b0, a_i};
    endcase
    case (sel_mult_b)
      2'h0:    mult_b = b_i;
      2'h1:    mult_b = fwd_operand_casc_i;
      2'h2:    mult_b = preadd_sum;
      default: mult_b = regfile_data_i;
    endcase
  end

  always @* begin
    case (sel_add_a)
      2'h0:    add_a = {{18{product[45]}}, product};
      2'h1:    add_a = {product, {`DMX_SHIFT_A{1'b0}}};
      2'h2:    add_a = {{16{packed_ab[47]}}, packed_ab};
      default: add_a = fwd_result_casc_i;
    endcase
    add_b_src = sel_add_b ? fwd_result_casc_i : acc;
    // arithmetic shift keeps the accumulator sign; kept out of the mux, whose
    // unsigned arm would otherwise turn the shift into a logical one
    add_b_shr = $signed(add_b_src) >>> `DMX_SHIFT_B;
    add_b = right_shift17_i ? add_b_shr : add_b_src;
    add_cin = sel_cin ? cascade_carry_i : local_carry_i;
  end

  always @* begin
    sum_out = bypass ? add_a : sum_wide[63:0];
    carry64 = bypass ? 1'b0 : sum_wide[64];
    carry48 = bypass ? 1'b0 : sum_low[48];
    ovf_pos = !bypass && !add_a[63] && !add_b[63] && sum_out[63];
    ovf_neg = !bypass && add_a[63] && add_b[63] && !sum_out[63];
    case (sel_rout)
      2'h0:    next_result = sum_out[44:0];
      2'h1:    next_result = {13'h0000, sum_out[63:32]};
      2'h2:    next_result = {13'h0000, rev_result_casc_i};
      default: next_result = 45'h000000000000;
    endcase
    case (sel_fwd_res)
      2'h0:    fwd_result_casc_o = sum_out;
      2'h1:    fwd_result_casc_o = acc;
      2'h2:    fwd_result_casc_o = fwd_result_casc_i;
      default: fwd_result_casc_o = 64'h0000000000000000;
    endcase
  end

  // unregistered so a chain of slices settles in one cycle
  assign cascade_carry_o = sel_fwd_c ? cascade_carry_pass_i : own_carry;

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      acc            <= 64'h0000000000000000;
      result_o       <= 45'h000000000000;
      pos_ovf_o      <= 1'b0;
      neg_ovf_o      <= 1'b0;
      match_o        <= 1'b0;
      result_carry_o <= 1'b0;
    end else begin
      acc            <= sum_out;
      result_o       <= next_result;
      result_carry_o <= own_carry;
      if (wide48) begin
        pos_ovf_o <= sum_out[47];
        neg_ovf_o <= sum_out[46];
        match_o   <= sum_out[45];
      end else begin
        pos_ovf_o <= ovf_pos;
        neg_ovf_o <= ovf_neg;
        match_o   <= pat_hit;
      end
    end
  end

  // ---------------- AXI4-Lite slave ----------------
  assign s_axi_awready_o = !aw_held;
  assign s_axi_wready_o  = !w_held;
  assign s_axi_arready_o = !s_axi_rvalid_o;

  wire do_write = aw_held && w_held && !s_axi_bvalid_o;
  wire wr_ok    = is_mapped(aw_addr);
  wire [`DMX_ST_BITS-1:0] events = wide48 ? 3'h0 : {pat_hit, ovf_neg, ovf_pos};
  wire clr_stat = do_write && (aw_addr == `DMX_OFS_STATUS) && w_strb[0];
  wire [31:0] cfg_wr = apply_strb({15'h0000, cfg}, w_data, w_strb);

  assign irq_o = |(status & irq_mask);

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      aw_addr        <= 5'h00;
      aw_held        <= 1'b0;
      w_data         <= 32'h00000000;
      w_strb         <= 4'h0;
      w_held         <= 1'b0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= `DMX_RESP_OKAY;
    end else begin
      if (s_axi_awvalid_i && !aw_held) begin
        aw_addr <= s_axi_awaddr_i;
        aw_held <= 1'b1;
      end
      if (s_axi_wvalid_i && !w_held) begin
        w_data <= s_axi_wdata_i;
        w_strb <= s_axi_wstrb_i;
        w_held <= 1'b1;
      end
      if (do_write) begin
        aw_held        <= 1'b0;
        w_held         <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o  <= wr_ok ? `DMX_RESP_OKAY : `DMX_RESP_SLVERR;
      end else if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
    end
  end

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cfg      <= `DMX_CFG_RESET;
      irq_mask <= `DMX_MASK_RESET;
      pattern  <= `DMX_PAT_RESET;
      pat_mask <= `DMX_PMASK_RESET;
      status   <= 3'h0;
    end else begin
      // a new event wins over a write-one-to-clear in the same cycle
      status <= (clr_stat ? (status & ~w_data[`DMX_ST_BITS-1:0]) : status) | events;
      if (do_write) begin
        if (aw_addr == `DMX_OFS_CFG) begin
          cfg <= cfg_wr[`DMX_CFG_BITS-1:0];
        end else if (aw_addr == `DMX_OFS_IRQ_MASK) begin
          if (w_strb[0]) begin
            irq_mask <= w_data[`DMX_ST_BITS-1:0];
          end
        end else if (aw_addr == `DMX_OFS_PATTERN) begin
          pattern <= apply_strb(pattern, w_data, w_strb);
        end else if (aw_addr == `DMX_OFS_PAT_MASK) begin
          pat_mask <= apply_strb(pat_mask, w_data, w_strb);
        end
      end
    end
  end

  reg [31:0] rd_word;
  always @* begin
    if (s_axi_araddr_i == `DMX_OFS_CFG) begin
      rd_word = {15'h0000, cfg};
    end else if (s_axi_araddr_i == `DMX_OFS_STATUS) begin
      rd_word = {29'h00000000, status};
    end else if (s_axi_araddr_i == `DMX_OFS_IRQ_MASK) begin
      rd_word = {29'h00000000, irq_mask};
    end else if (s_axi_araddr_i == `DMX_OFS_PATTERN) begin
      rd_word = pattern;
    end else if (s_axi_araddr_i == `DMX_OFS_PAT_MASK) begin
      rd_word = pat_mask;
    end else if (s_axi_araddr_i == `DMX_OFS_ACC_LO) begin
      rd_word = acc[31:0];
    end else if (s_axi_araddr_i == `DMX_OFS_ACC_HI) begin
      rd_word = acc[63:32];
    end else begin
      rd_word = 32'h00000000;
    end
  end

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o  <= 32'h00000000;
      s_axi_rresp_o  <= `DMX_RESP_OKAY;
    end else if (s_axi_arvalid_i && !s_axi_rvalid_o) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o  <= rd_word;
      s_axi_rresp_o  <= is_mapped(s_axi_araddr_i) ? `DMX_RESP_OKAY : `DMX_RESP_SLVERR;
    end else if (s_axi_rvalid_o && s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end
endmodule // dmx_slice

// file: tb/dmx_slice_asserts.sv
// handshake checker for the slice register bus
`timescale 1ns/100ps
module dmx_slice_asserts (
  input wire        clk_i,
  input wire        resetn_i,
  input wire        s_axi_awvalid_i,
  input wire        s_axi_awready_o,
  input wire        s_axi_wvalid_i,
  input wire        s_axi_wready_o,
  input wire [1:0]  s_axi_bresp_o,
  input wire        s_axi_bvalid_o,
  input wire        s_axi_bready_i,
  input wire        s_axi_arvalid_i,
  input wire        s_axi_arready_o,
  input wire [31:0] s_axi_rdata_o,
  input wire        s_axi_rvalid_o,
  input wire        s_axi_rready_i
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_wr_pair;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  endsequence
  sequence s_wr_busy;
    !s_axi_awready_o && !s_axi_wready_o;
  endsequence
  property p_wr_answer;
    s_wr_pair |=> s_wr_busy ##1 s_axi_bvalid_o;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write answer missing");
  property p_b_hold;
    s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_b_done;
    s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o;
  endproperty
  a_b_done: assert property (p_b_done) else $error("write response repeated");
  property p_ar_answer;
    s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o;
  endproperty
  a_ar_answer: assert property (p_ar_answer) else $error("read answer late");
  property p_r_hold;
    s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_r_done;
    s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o;
  endproperty
  a_r_done: assert property (p_r_done) else $error("read data repeated");
  property p_aw_gate;
    s_axi_awvalid_i && s_axi_awready_o |=> !s_axi_awready_o;
  endproperty
  a_aw_gate: assert property (p_aw_gate) else $error("write address ready wrong");
  property p_r_cause;
    $rose(s_axi_rvalid_o) |-> $past(s_axi_arvalid_i && s_axi_arready_o);
  endproperty
  a_r_cause: assert property (p_r_cause) else $error("read data without request");
endmodule // dmx_slice_asserts

bind dmx_slice dmx_slice_asserts dmx_slice_asserts_inst (
  .clk_i, .resetn_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o,
  .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_arvalid_i, .s_axi_arready_o,
  .s_axi_rdata_o, .s_axi_rvalid_o, .s_axi_rready_i);

// file: tb/dmx_nbr_model.sv
// neighbouring slices: values on the cascade buses from below and above
`timescale 1ns/100ps
module dmx_nbr_model (
  input  wire        clk_i,
  input  wire        step_i,
  output wire [63:0] fwd_result_o,
  output wire [31:0] rev_result_o,
  output wire [26:0] fwd_operand_o,
  output wire        carry_o,
  output wire        carry_pass_o
);
  reg [63:0] st = 64'h1;
  // new values only on request, so the bench can hold them across a check
  always @(posedge clk_i) begin
    if (step_i) begin
      st <= st * 64'h5851F42D4C957F2D + 64'h14057B7EF767814F;
    end
  end
  assign fwd_result_o  = st;
  assign rev_result_o  = st[50:19];
  assign fwd_operand_o = st[62:36];
  assign carry_o       = st[63] ^ st[7];
  assign carry_pass_o  = st[3] ^ st[60];
endmodule // dmx_nbr_model

// file: tb/testbench.sv
// self-checking bench for the slice datapath and its register bus
`timescale 1ns/100ps
`include "dmx_map.vh"
module testbench;
  reg         clk_i = 1'b0, resetn_i = 1'b0, step = 1'b0;
  reg  [4:0]  s_axi_awaddr_i = 5'h00, s_axi_araddr_i = 5'h00;
  reg  [31:0] s_axi_wdata_i = 32'h0, rnd = 32'hADB2309A, d;
  reg  [3:0]  s_axi_wstrb_i = 4'hF;
  reg         s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b1;
  reg         s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b1;
  reg  [17:0] a_i = 18'h0;
  reg  [26:0] b_i = 27'h0, regfile_data_i = 27'h0;
  reg  [2:0]  regfile_index_i = 3'h0;
  reg         local_carry_i = 1'b0, right_shift17_i = 1'b0, co;
  wire        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  wire [1:0]  s_axi_bresp_o, s_axi_rresp_o;
  wire [31:0] s_axi_rdata_o, rev_result_casc_i;
  wire [44:0] result_o;
  wire [63:0] fwd_result_casc_i, fwd_result_casc_o;
  wire [26:0] fwd_operand_casc_i;
  wire        pos_ovf_o, neg_ovf_o, match_o, result_carry_o, cascade_carry_o, irq_o;
  wire        cascade_carry_i, cascade_carry_pass_i;
  int         num_errors = 0, cmp_count = 0, cyc = 0, i, sel, wide, fs, cs, ks, ma, mb, sh, po;
  reg  [1:0]  r, ov;
  reg  [63:0] v, bb;
  reg  [64:0] s65;
  reg  [48:0] s49;
  dmx_slice dmx_slice_inst (
    .clk_i, .resetn_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i,
    .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o,
    .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o,
    .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .a_i, .b_i, .regfile_data_i,
    .regfile_index_i, .fwd_operand_casc_i, .fwd_result_casc_i, .rev_result_casc_i,
    .local_carry_i, .cascade_carry_i, .cascade_carry_pass_i, .right_shift17_i, .result_o,
    .pos_ovf_o, .neg_ovf_o, .match_o, .result_carry_o, .fwd_result_casc_o, .cascade_carry_o,
    .irq_o);
  dmx_nbr_model dmx_nbr_model_inst (.clk_i, .step_i(step), .fwd_result_o(fwd_result_casc_i),
    .rev_result_o(rev_result_casc_i), .fwd_operand_o(fwd_operand_casc_i),
    .carry_o(cascade_carry_i), .carry_pass_o(cascade_carry_pass_i));
  initial forever #5 clk_i = ~clk_i;
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function [63:0] cat(input [2:0] x, input [17:0] p, input [26:0] q);
    cat = {{16{x[2]}}, x, p, q};
  endfunction
  function [1:0] ovf(input [63:0] x, input [63:0] y, input [63:0] s);
    ovf = {!x[63] && !y[63] && s[63], x[63] && y[63] && !s[63]};
  endfunction
  // adder A operand built from the multiplier path
  function [63:0] prod(input [1:0] ma, input [1:0] mb, input sh, input [17:0] x,
                       input [26:0] y, input [26:0] rf, input [26:0] fo, input [1:0] po);
    reg        [26:0] xs, p;
    reg signed [18:0] ua;
    reg signed [26:0] ub;
    reg signed [45:0] pr;
    begin
      xs = {{9{x[17]}}, x};
      p = po == 0 ? xs + y : po == 1 ? xs - y : po == 2 ? y - xs : 27'h0;
      ua = ma == 0 ? {x[17], x} : ma == 1 ? p[18:0] : ma == 2 ? rf[18:0] : {1'b0, x};
      ub = mb == 0 ? y : mb == 1 ? fo : mb == 2 ? p : rf;
      pr = ua * ub;
      prod = sh ? {pr, 18'h0} : {{18{pr[45]}}, pr};
    end
  endfunction
  task conclude;
    $display("mismatches %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input [63:0] got, input [63:0] exp, input [8*10:1] what);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t %0s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task chk_r(input [1:0] got, input [1:0] exp);
    chk({62'h0, got}, {62'h0, exp}, "response");
  endtask
  // ready stays high; the answer is taken in the half cycle before its handshake edge
  task axw(input [4:0] ad, input [31:0] dt, input [1:0] er);
    int n;
    reg aw, w, bv, bd;
    s_axi_awaddr_i <= ad; s_axi_wdata_i <= dt; s_axi_awvalid_i <= 1; s_axi_wvalid_i <= 1;
    n = 0; bd = 0;
    while (!bd && n < 50) begin
      @(negedge clk_i);
      aw = s_axi_awvalid_i && s_axi_awready_o; w = s_axi_wvalid_i && s_axi_wready_o;
      bv = s_axi_bvalid_o; bd = bv && s_axi_bready_i; r = s_axi_bresp_o;
      @(posedge clk_i);
      if (aw) s_axi_awvalid_i <= 0;
      if (w) s_axi_wvalid_i <= 0;
      n++;
    end
    chk_r(bd ? r : ~er, er);
  endtask
  task axr(input [4:0] ad, input [31:0] ed, input [1:0] er);
    int n;
    reg ar, rv, rd;
    s_axi_araddr_i <= ad; s_axi_arvalid_i <= 1; n = 0; rd = 0;
    while (!rd && n < 50) begin
      @(negedge clk_i);
      ar = s_axi_arvalid_i && s_axi_arready_o; rv = s_axi_rvalid_o;
      rd = rv && s_axi_rready_i; d = s_axi_rdata_o; r = s_axi_rresp_o;
      @(posedge clk_i);
      if (ar) s_axi_arvalid_i <= 0;
      n++;
    end
    chk(d, ed, "read data"); chk_r(rd ? r : ~er, er);
  endtask
  task go;
    rnd = lfsr(rnd); a_i <= rnd[17:0]; local_carry_i <= rnd[18]; right_shift17_i <= rnd[19];
    rnd = lfsr(rnd); b_i <= rnd[26:0]; regfile_index_i <= rnd[29:27]; step <= 1;
    regfile_data_i <= ~rnd[26:0];
    @(posedge clk_i); step <= 0;
    @(negedge clk_i);
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin num_errors++; conclude; end
  end
  initial begin
    repeat (12) @(posedge clk_i);
    resetn_i <= 1;
    @(posedge clk_i);
    axr(`DMX_OFS_CFG, 0, `DMX_RESP_OKAY);
    axr(5'h1C, 0, `DMX_RESP_SLVERR);
    axw(5'h1C, 32'hFFFFFFFF, `DMX_RESP_SLVERR);
    $display("test registers done");
    for (i = 0; i < 8; i++) begin
      sel = i % 4; wide = i / 4;
      axw(`DMX_OFS_CFG, (1 << `DMX_F_BYPASS) | (2 << `DMX_F_ADD_A) | (sel << `DMX_F_ROUT)
          | (wide << `DMX_F_WIDE48), `DMX_RESP_OKAY);
      go; @(posedge clk_i); @(negedge clk_i);
      v = cat(regfile_index_i, a_i, b_i);
      chk(result_o, sel == 0 ? v[44:0] : sel == 1 ? {13'h0, v[63:32]} : sel == 2 ?
          {13'h0, rev_result_casc_i} : 0, "bypass");
      chk({pos_ovf_o, neg_ovf_o, match_o}, wide ? v[47:45] : 3'h1, "flags");
      @(posedge clk_i);
    end
    axr(`DMX_OFS_ACC_LO, v[31:0], `DMX_RESP_OKAY);
    axr(`DMX_OFS_ACC_HI, v[63:32], `DMX_RESP_OKAY);
    $display("test bypass routing done");
    for (i = 0; i < 24; i++) begin
      rnd = lfsr(rnd); fs = rnd % 3; cs = rnd[4]; ks = rnd[5]; wide = rnd[6];
      axw(`DMX_OFS_CFG, (3 << `DMX_F_ADD_A) | (1 << `DMX_F_ADD_B) | (cs << `DMX_F_CIN)
          | (wide << `DMX_F_WIDE48) | (fs << `DMX_F_FWD_RES) | (ks << `DMX_F_FWD_CARRY),
          `DMX_RESP_OKAY);
      go;
      bb = fwd_result_casc_i;
      if (right_shift17_i) bb = $signed(bb) >>> 17;
      co = cs ? cascade_carry_i : local_carry_i;
      s65 = {1'b0, fwd_result_casc_i} + {1'b0, bb} + co;
      s49 = fwd_result_casc_i[47:0] + bb[47:0] + co;
      ov = ovf(fwd_result_casc_i, bb, s65[63:0]);
      co = wide ? s49[48] : s65[64];
      if (fs != 1) chk(fwd_result_casc_o, fs ? fwd_result_casc_i : s65[63:0], "fwd");
      chk(cascade_carry_o, ks ? cascade_carry_pass_i : co, "casc co");
      @(posedge clk_i); @(negedge clk_i);
      chk(result_o, s65[44:0], "sum");
      chk(result_carry_o, co, "carry");
      if (fs == 1) chk(fwd_result_casc_o, s65[63:0], "fwd reg");
      if (wide) chk({pos_ovf_o, neg_ovf_o, match_o}, s65[47:45], "wide");
      else chk({pos_ovf_o, neg_ovf_o, match_o}, {ov, 1'b1}, "flags");
      @(posedge clk_i);
    end
    $display("test adder routing done");
    for (i = 0; i < 24; i++) begin
      rnd = lfsr(rnd); ma = rnd[1:0]; mb = rnd[3:2]; sh = rnd[4]; po = rnd[6:5];
      axw(`DMX_OFS_CFG, (ma << `DMX_F_MULT_A) | (mb << `DMX_F_MULT_B) | (sh << `DMX_F_ADD_A)
          | (1 << `DMX_F_FWD_RES) | (po << `DMX_F_PREADD), `DMX_RESP_OKAY);
      go;
      v = prod(ma, mb, sh, a_i, b_i, regfile_data_i, fwd_operand_casc_i, po);
      bb = fwd_result_casc_o;
      if (right_shift17_i) bb = $signed(bb) >>> 17;
      s65 = {1'b0, v} + {1'b0, bb} + local_carry_i;
      ov = ovf(v, bb, s65[63:0]);
      @(posedge clk_i); @(negedge clk_i);
      chk(result_o, s65[44:0], "mac");
      chk(fwd_result_casc_o, s65[63:0], "mac acc");
      chk(result_carry_o, s65[64], "mac carry");
      chk({pos_ovf_o, neg_ovf_o, match_o}, {ov, 1'b1}, "mac flags");
      @(posedge clk_i);
    end
    $display("test multiplier routing done");
    axw(`DMX_OFS_CFG, 0, `DMX_RESP_OKAY);
    axw(`DMX_OFS_IRQ_MASK, 4, `DMX_RESP_OKAY);
    @(negedge clk_i) chk(irq_o, 1, "irq on");
    @(posedge clk_i) axw(`DMX_OFS_IRQ_MASK, 0, `DMX_RESP_OKAY);
    @(negedge clk_i) chk(irq_o, 0, "irq masked");
    @(posedge clk_i) axw(`DMX_OFS_IRQ_MASK, 4, `DMX_RESP_OKAY);
    axw(`DMX_OFS_CFG, 1 << `DMX_F_WIDE48, `DMX_RESP_OKAY);
    axw(`DMX_OFS_STATUS, 7, `DMX_RESP_OKAY);
    @(negedge clk_i) chk(irq_o, 0, "irq clear");
    @(posedge clk_i) axr(`DMX_OFS_STATUS, 0, `DMX_RESP_OKAY);
    axr(`DMX_OFS_IRQ_MASK, 4, `DMX_RESP_OKAY);
    $display("test interrupt done");
    conclude;
  end
endmodule // testbench
